// *** src/bmft_pkg.sv ***
// Purpose: shared constants and types for the biphase-mark frame transmitter
// Assumes: 200 MHz system clock, one clock domain
// Notes: bit period is set in clock cycles by a configuration input
package bmft_pkg;
   // clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // shortest and longest unit bit period, nanoseconds
   localparam int unsigned BIT_MIN_NS = 40000;
   localparam int unsigned BIT_MAX_NS = 3200000;
   // cycle counts for the bit period range (min rounds up, max down)
   localparam int unsigned BIT_MIN_CYC =
      (BIT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned BIT_MAX_CYC = (BIT_MAX_NS / 5) * 1000 / 1000;
   // width of the bit period counter
   localparam int unsigned PER_W = 20;
   // frame layout in unit bit periods
   localparam int unsigned PAYLOAD_BITS = 14;
   localparam int unsigned READ_BITS = 12;
   localparam int unsigned GAP_BITS = 8;
   localparam int unsigned FRAME_BITS = 24;
   // index of the first gap bit (sync + payload + parity)
   localparam logic [4:0] GAP_START = 5'h10;
   // last bit index of the frame
   localparam logic [4:0] LAST_BIT = 5'h17;
   // mid-bit transition point for a one, percent of the bit period
   localparam int unsigned ONE_PCT = 65;
   // part-number announcements after power-up
   localparam logic [1:0] ANNOUNCE_COUNT = 2'h2;
   // quiescent output level and level after reset
   localparam logic IDLE_LEVEL = 1'b1;
   // bit period after reset, cycles
   localparam logic [PER_W-1:0] PER_RESET = 20'h01f40;

   // frame sequencer states, gray along sync, data, gap
   typedef enum logic [1:0] {
      BMFT_SYNC = 2'b00,
      BMFT_DATA = 2'b01,
      BMFT_GAP = 2'b11
   } bmft_state_t;

   // configuration carried into the framer
   typedef struct packed {
      logic [PER_W-1:0] bit_cycles;
      logic announce_en;
      logic [1:0] low_bits;
   } bmft_cfg_t;
endpackage

// *** src/bmft_sync2.sv ***
// Purpose: two-flop synchroniser for a bus of pin-side levels
// Assumes: inputs are quasi-static levels
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module bmft_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // first and second stage
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;

   // two stages, cleared by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end
   assign q = s2_reg;
endmodule

// *** src/bmft_bitcell.sv ***
// Purpose: timing of one bit cell: end-of-bit and mid-bit strobes
// Assumes: period at least two cycles
// Notes: period is sampled at the start of each cell
`timescale 1ns/10ps
module bmft_bitcell #(
   parameter int PW = 20,
   // cell length until the first period is latched
   parameter logic [PW-1:0] RST_PER = PW'(bmft_pkg::PER_RESET)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [PW-1:0] period,
   output logic mid_pulse,
   output logic end_pulse
);
   // cycles elapsed in the cell
   logic [PW-1:0] cnt_reg;
   logic [PW-1:0] cnt_next;
   // period latched for this cell
   logic [PW-1:0] per_reg;
   // transition point within the cell
   logic [PW-1:0] mid_point;

   // scale period by the fixed fraction
   function automatic logic [PW-1:0] frac(input logic [PW-1:0] p);
      logic [PW+7:0] prod;
      prod = {8'h00, p} * (PW+8)'(bmft_pkg::ONE_PCT);
      frac = PW'(prod / (PW+8)'(100));
   endfunction

   assign mid_point = frac(per_reg);
   assign end_pulse = (cnt_reg == per_reg - PW'(1));
   assign mid_pulse = (cnt_reg == mid_point);
   assign cnt_next = end_pulse ? '0 : cnt_reg + PW'(1);

   // cell counter and period latch
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         per_reg <= RST_PER;
      end else begin
         cnt_reg <= cnt_next;
         if (end_pulse) begin
            per_reg <= period;
         end
      end
   end
endmodule

// *** src/bmft_framer.sv ***
// Purpose: biphase-mark frame transmitter on one output pin
// Assumes: reading and configuration come from pins, resynchronised here
// Notes: frame is sync, 14 payload, parity, 8-bit gap, 24 periods total
`timescale 1ns/10ps
module bmft_framer #(
   parameter int PW = bmft_pkg::PER_W,
   // shortest accepted bit period, cycles
   parameter int unsigned MIN_CYC = bmft_pkg::BIT_MIN_CYC,
   // bit period used until the first configured one, cycles
   parameter int unsigned RST_CYC = 32'(bmft_pkg::PER_RESET),
   parameter logic [11:0] PART_NUMBER = 12'h5a5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] reading,
   input wire logic [PW-1:0] bit_cycles,
   input wire logic announce_en,
   input wire logic [1:0] low_bits,
   output logic frame_out,
   output logic frame_valid,
   output logic frame_start
);
   // synchronised inputs
   logic [11:0] reading_s;
   bmft_pkg::bmft_cfg_t cfg_s;
   // sequencer state
   bmft_pkg::bmft_state_t state_reg;
   bmft_pkg::bmft_state_t state_next;
   // bit index within frame, 0..23
   logic [4:0] bit_reg;
   logic [4:0] bit_next;
   // frame word: payload and parity
   logic [13:0] frame_payload_bits_reg;
   logic payload_parity_bit_reg;
   // output level
   logic out_reg;
   logic out_next;
   // announcements still to send
   logic [1:0] ann_reg;
   // frames sent since reset, saturating at 2
   logic [1:0] sent_reg;
   // announcement option caught after reset
   logic ann_en_reg;
   logic strap_done_reg;
   // cell strobes
   logic mid_pulse;
   logic end_pulse;
   // clamped period
   logic [PW-1:0] period_c;
   // wires for next frame and current bit
   logic frame_end;
   logic [11:0] next_word;
   logic [13:0] next_payload;
   logic next_parity;
   logic cur_bit;
   logic is_one;

   // count of zero bits, even gives parity one
   function automatic logic zero_parity(input logic [13:0] d);
      zero_parity = ~(^(~d));
   endfunction

   // keep the period inside the documented range
   function automatic logic [PW-1:0] clamp(input logic [PW-1:0] p);
      if (p < PW'(MIN_CYC)) begin
         clamp = PW'(MIN_CYC);
      end else if (p > PW'(bmft_pkg::BIT_MAX_CYC)) begin
         clamp = PW'(bmft_pkg::BIT_MAX_CYC);
      end else begin
         clamp = p;
      end
   endfunction

   // pin inputs pass two flops
   bmft_sync2 #(
      .W(12 + PW + 3)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({reading, bit_cycles, announce_en, low_bits}),
      .q({reading_s, cfg_s})
   );

   assign period_c = clamp(cfg_s.bit_cycles);

   bmft_bitcell #(
      .PW(PW),
      .RST_PER(PW'(RST_CYC))
   ) u_cell (
      .clk(clk),
      .rst(rst),
      .period(period_c),
      .mid_pulse(mid_pulse),
      .end_pulse(end_pulse)
   );

   assign frame_end = end_pulse && (bit_reg == bmft_pkg::LAST_BIT);
   assign next_word = (ann_reg != 2'h0) ? PART_NUMBER : reading_s;
   // reading or part number on top, configured low bits
   assign next_payload = {next_word, cfg_s.low_bits};
   assign next_parity = zero_parity(next_payload);

   // current bit value: payload msb first, then parity
   assign cur_bit = (state_reg == bmft_pkg::BMFT_DATA) ?
      ((bit_reg == 5'h0f) ? payload_parity_bit_reg :
       frame_payload_bits_reg[4'(5'd14 - bit_reg)]) : 1'b0;
   assign is_one = cur_bit && (state_reg == bmft_pkg::BMFT_DATA);

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      bit_next = bit_reg;
      if (end_pulse) begin
         bit_next = frame_end ? 5'h00 : bit_reg + 5'h01;
         case (state_reg)
            bmft_pkg::BMFT_SYNC: begin
               state_next = bmft_pkg::BMFT_DATA;
            end
            bmft_pkg::BMFT_DATA: begin
               if (bit_reg == 5'h0f) begin
                  state_next = bmft_pkg::BMFT_GAP;
               end
            end
            bmft_pkg::BMFT_GAP: begin
               if (frame_end) begin
                  state_next = bmft_pkg::BMFT_SYNC;
               end
            end
            default: begin
               state_next = bmft_pkg::BMFT_SYNC;
            end
         endcase
      end
   end

   // output level next value
   always_comb begin
      out_next = out_reg;
      if (end_pulse) begin
         if (frame_end) begin
            // sync starts by leaving idle level
            out_next = ~bmft_pkg::IDLE_LEVEL;
         end else if (bit_next < bmft_pkg::GAP_START) begin
            out_next = ~out_reg;
         end else if (bit_reg == 5'h0f) begin
            out_next = ~out_reg;
         end
      end else if (mid_pulse && is_one) begin
         out_next = ~out_reg;
      end
   end

   // sequencer, bit index and output
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= bmft_pkg::BMFT_GAP;
         bit_reg <= bmft_pkg::GAP_START;
         out_reg <= bmft_pkg::IDLE_LEVEL;
      end else begin
         state_reg <= state_next;
         bit_reg <= bit_next;
         out_reg <= out_next;
      end
   end

   // latch frame word at frame start
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_payload_bits_reg <= '0;
         payload_parity_bit_reg <= 1'b0;
      end else if (frame_end) begin
         frame_payload_bits_reg <= next_payload;
         payload_parity_bit_reg <= next_parity;
      end
   end

   // catch announcement option until the first frame starts
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_done_reg <= 1'b0;
         ann_en_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         // synchroniser has settled long before the first frame end
         strap_done_reg <= frame_end;
         ann_en_reg <= cfg_s.announce_en;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ann_reg <= 2'h0;
      end else if (frame_end && (sent_reg == 2'h0) && ann_en_reg) begin
         // frames two and three carry the part number
         ann_reg <= bmft_pkg::ANNOUNCE_COUNT;
      end else if (frame_end && (ann_reg != 2'h0)) begin
         ann_reg <= ann_reg - 2'h1;
      end
   end

   // first frame after reset flagged invalid
   always_ff @(posedge clk) begin
      if (rst) begin
         sent_reg <= 2'h0;
      end else if (frame_end && (sent_reg != 2'h2)) begin
         sent_reg <= sent_reg + 2'h1;
      end
   end

   // frame_out from a flop, frame_valid and frame_start decoded from flops; valid marks frames after the first
   assign frame_out = out_reg;
   assign frame_valid = (sent_reg == 2'h2);
   assign frame_start = frame_end;
endmodule

// *** tb/bmft_framer_assertions.sv ***
// Purpose: port checks for the frame transmitter
// Assumes: bit period input held steady
// Notes: positions count from each frame start
`timescale 1ns/10ps
module bmft_framer_checker #(
   parameter int PW = 20,
   parameter int unsigned MIN_CYC = bmft_pkg::BIT_MIN_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] reading,
   input wire logic [PW-1:0] bit_cycles,
   input wire logic announce_en,
   input wire logic [1:0] low_bits,
   input wire logic frame_out,
   input wire logic frame_valid,
   input wire logic frame_start
);
   int unsigned b, p, ph, c_reg; // period in, clamped, bit phase, position
   logic on_reg; // a frame start was seen
   assign b = 32'(bit_cycles);
   assign p = b < MIN_CYC ? MIN_CYC :
      (b > bmft_pkg::BIT_MAX_CYC ? bmft_pkg::BIT_MAX_CYC : b);
   assign ph = (c_reg - 1) % p;
   // position counter, restarts at each frame start
   always_ff @(posedge clk) begin
      if (rst) begin
         on_reg <= 1'b0;
         c_reg <= 0;
      end else begin
         on_reg <= on_reg | frame_start;
         c_reg <= frame_start ? 1 : c_reg + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   reset_idle_a:
      assert property (disable iff (1'b0) rst |=> frame_out && !frame_start
         && !frame_valid) else $error("not idle in reset");
   sync_fall_a:
      assert property (frame_start |=> $fell(frame_out))
         else $error("sync did not fall");
   sync_low_a:
      assert property (on_reg && c_reg <= p |-> !frame_out)
         else $error("sync not low");
   bit_edge_a:
      assert property (on_reg && c_reg > 1 && c_reg <= 16 * p + 1 && ph == 0
         |-> $changed(frame_out)) else $error("no bit end toggle");
   mid_edge_a:
      assert property (on_reg && $changed(frame_out) && ph != 0
         |-> ph >= p / 2 && ph <= p * 4 / 5) else $error("stray toggle");
   gap_quiet_a:
      assert property (on_reg && c_reg > 16 * p + 1 |-> $stable(frame_out)
         && frame_out) else $error("gap not quiet");
   frame_len_a:
      assert property (on_reg |-> c_reg <= 24 * p
         && frame_start == (c_reg == 24 * p)) else $error("frame length");
   valid_rise_a:
      assert property ($rose(frame_valid) |-> $past(on_reg)
         && ($past(frame_start) || frame_start)) else $error("early valid");
   valid_hold_a:
      assert property (frame_valid |=> frame_valid)
         else $error("valid dropped");
   cover property (frame_start && on_reg);
   cover property ($rose(frame_valid));
   cover property (on_reg && $changed(frame_out) && ph != 0);
endmodule
bind bmft_framer bmft_framer_checker #(.PW(PW), .MIN_CYC(MIN_CYC)) chk (
   .clk, .rst, .reading,
   .bit_cycles, .announce_en, .low_bits, .frame_out, .frame_valid,
   .frame_start);

// *** tb/bmft_rx_model.sv ***
// Purpose: receiver decoding the biphase-mark line
// Assumes: line quiet between frames
// Notes: period taken from the sync bit
`timescale 1ns/10ps
module bmft_rx_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic frame_out,
   output logic [14:0] word,
   output int period,
   output logic got
);
   logic last, half, busy; // line history, half seen, in frame
   int t; // cycles since last edge
   logic [4:0] n; // bits taken, 0 is sync
   always_ff @(posedge clk) begin
      last <= frame_out;
      got <= 1'b0;
      t <= t + 1;
      if (rst) begin
         busy <= 1'b0;
         t <= 0;
      end else if (frame_out != last) begin
         t <= 1;
         if (!busy) begin
            busy <= 1'b1;
            n <= 5'h00;
            half <= 1'b0;
         end else if (n == 5'h00) begin
            period <= t;
            n <= 5'h01;
         end else if (t * 10 > period * 9 || half) begin
            // full interval is a zero, second short one ends a one
            word <= {word[13:0], half};
            half <= 1'b0;
            n <= n + 5'h01;
            busy <= n != 5'h0f;
            got <= n == 5'h0f;
         end else begin
            half <= 1'b1;
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Purpose: bench for the frame transmitter
// Assumes: bit period shortened to 40 cycles to keep the run short
// Notes: frames judged through the receiver model
`timescale 1ns/10ps
module tb_top;
   logic clk, rst, announce_en, frame_out, frame_valid, frame_start, got;
   logic [11:0] reading;
   logic [19:0] bit_cycles;
   logic [1:0] low_bits;
   logic [14:0] word;
   int period, mismatches, comparisons;
   bmft_framer #(.MIN_CYC(40), .RST_CYC(40)) dut (.clk, .rst, .reading,
      .bit_cycles, .announce_en,
      .low_bits, .frame_out, .frame_valid, .frame_start);
   bmft_rx_model rx (.clk, .rst, .frame_out, .word, .period, .got);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // count and judge one result
   task automatic cmp(string s, logic [31:0] e, logic [31:0] v);
      comparisons++;
      if (v !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", s, e, v);
      end
   endtask
   // payload then parity, one when zero count even
   function automatic logic [14:0] xw(logic [11:0] r, logic [1:0] l);
      return {r, l, ~^{r, l}};
   endfunction
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // bounded wait for the next decoded word
   task automatic wait_word();
      int i;
      @(negedge clk);
      for (i = 0; i < 2000 && got !== 1'b1; i++) @(negedge clk);
      if (got !== 1'b1) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic t_reset();
      cmp("idle level", 1, frame_out);
      cmp("reset valid", 0, frame_valid);
      cmp("reset start", 0, frame_start);
   endtask
   task automatic t_first();
      wait_word();
      cmp("bit period", 40, period);
      cmp("first valid", 0, frame_valid);
   endtask
   task automatic t_announce();
      repeat (2) begin
         wait_word();
         cmp("part number", 12'h5a5, word[14:3]);
         cmp("later valid", 1, frame_valid);
      end
   endtask
   // change the reading well inside a frame
   task automatic t_refresh();
      int i;
      for (i = 0; i < 2000 && frame_start !== 1'b1; i++) @(negedge clk);
      cmp("frame start", 1, frame_start);
      repeat (400) @(negedge clk);
      reading = 12'hc35;
      low_bits = 2'b01;
      wait_word();
      cmp("held word", xw(12'h000, 2'b00), word);
      wait_word();
      cmp("new word", xw(12'hc35, 2'b01), word);
      cmp("odd parity", 0, word[0]);
   endtask
   initial begin
      rst = 1'b1;
      announce_en = 1'b1;
      reading = 12'h000;
      low_bits = 2'b00;
      bit_cycles = 20'h00028;
      mismatches = 0;
      comparisons = 0;
      repeat (16) @(negedge clk);
      t_reset();
      rst = 1'b0;
      t_first();
      t_announce();
      t_refresh();
      summarize();
   end
endmodule
